// ---- verilog/rss_top.sv ----
// top level of the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_top (
	// clock and reset of the register side and the delay sequencer; the synchronisers take the clock only
	input wire logic clk,
	input wire logic nrst,
	// detectors and sources
	input wire logic powerOnLow,
	input wire logic pinResetN,
	input wire logic watchdogExpire,
	input wire logic watchdogEnable,
	input wire logic [1:0] brownoutCompare,
	input wire logic testResetBit,
	// nonvolatile configuration
	input wire logic [1:0] brownoutLevelSelect,
	input wire logic [1:0] startupTimeSelect,
	input wire logic [1:0] clockSourceSelect,
	// reset outputs
	output logic coreResetN,
	output logic portResetN,
	output logic [1:0] brownoutThresholdSel,
	output logic irq,
	// axi4-lite slave
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	rss_reg_if rif();
	rss_pkg::rss_state_type state_r;
	rss_pkg::rss_state_type state_nxt;
	logic [1:0] porSync_r;
	logic [1:0] pinSync_r;
	logic [1:0] wdtSync_r;
	logic [1:0] wdtEnSync_r;
	logic [1:0] brnSync_r;
	logic [1:0] tstSync_r;
	logic wdtPrev_r;
	logic [15:0] pinLowCnt_r;
	logic pinQual_r;
	logic pinPrev_r;
	logic [15:0] delay_r;
	logic [15:0] delay_nxt;
	logic [15:0] tout;
	logic wdtPulse;
	logic brnEnabled;
	logic anySource;
	logic [4:0] causeNow;

	function automatic logic [15:0] pickTimeout(input logic [3:0] sel);
		case (sel[1:0] ^ sel[3:2])
			2'h0: pickTimeout = rss_pkg::TOUT_SEL0;
			2'h1: pickTimeout = rss_pkg::TOUT_SEL1;
			2'h2: pickTimeout = rss_pkg::TOUT_SEL2;
			default: pickTimeout = rss_pkg::TOUT_SEL3;
		endcase
	endfunction

	// ************
	// input synchronisers
	// ************
	always_ff @(posedge clk) begin
		porSync_r <= {porSync_r[0], powerOnLow};
		pinSync_r <= {pinSync_r[0], pinResetN};
		wdtSync_r <= {wdtSync_r[0], watchdogExpire};
		wdtEnSync_r <= {wdtEnSync_r[0], watchdogEnable};
		brnSync_r <= {brnSync_r[0], brownoutCompare[0]};
		tstSync_r <= {tstSync_r[0], testResetBit};
	end

	// ************
	// source qualification
	// ************
	assign brnEnabled = brownoutLevelSelect != rss_pkg::BRN_OFF;
	assign brownoutThresholdSel = brownoutLevelSelect;
	// detector flags below the selected level; ignored when disabled
	wire brnLow = brnSync_r[1] && brnEnabled;
	// single-cycle pulse on the rising edge of expiry, enable-gated
	assign wdtPulse = wdtSync_r[1] && !wdtPrev_r && wdtEnSync_r[1];
	wire pinLow = !pinSync_r[1];
	wire pinRise = pinSync_r[1] && !pinPrev_r;
	assign anySource = porSync_r[1] || pinQual_r || wdtPulse || brnLow || tstSync_r[1];
	assign causeNow = {tstSync_r[1], wdtPulse, brnLow, pinQual_r, porSync_r[1]};
	assign tout = pickTimeout({startupTimeSelect, clockSourceSelect});

	// pin low must outlast the minimum width before it counts
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pinLowCnt_r <= 16'h0000;
			pinQual_r <= 1'b0;
			pinPrev_r <= 1'b1;
			wdtPrev_r <= 1'b0;
		end else begin
			pinPrev_r <= pinSync_r[1];
			wdtPrev_r <= wdtSync_r[1];
			if (!pinLow) begin
				pinLowCnt_r <= 16'h0000;
				pinQual_r <= 1'b0;
			end else if (pinLowCnt_r >= 16'(rss_pkg::PIN_MIN_CYC)) begin
				pinQual_r <= 1'b1;
			end else begin
				pinLowCnt_r <= pinLowCnt_r + 16'h0001;
			end
		end
	end

	// ************
	// delay sequencer
	// ************
	always_comb begin
		state_nxt = state_r;
		delay_nxt = delay_r;
		case (state_r)
			rss_pkg::ST_HOLD: begin
				delay_nxt = 16'h0000;
				if (!anySource || pinRise) begin
					state_nxt = rss_pkg::ST_COUNT;
				end
			end
			rss_pkg::ST_COUNT: begin
				if (anySource) begin
					state_nxt = rss_pkg::ST_HOLD;
				end else if (delay_r + 16'h0001 >= tout) begin
					state_nxt = rss_pkg::ST_RUN;
				end else begin
					delay_nxt = delay_r + 16'h0001;
				end
			end
			rss_pkg::ST_RUN: begin
				if (anySource) begin
					state_nxt = rss_pkg::ST_HOLD;
				end
			end
			default: state_nxt = rss_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= rss_pkg::ST_HOLD;
			delay_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			delay_r <= delay_nxt;
		end
	end

	// ************
	// reset outputs
	// ************
	// raw power-on, test and pin levels gate the outputs so they act with no
	// clock; the second sync stage bridges the gap until the sequencer leaves
	// run. limitation: a source pulse shorter than one clock may skip the stretch
	// ports follow the raw pin at once; the core waits for the filtered pin, so a
	// short pin glitch may reset the ports alone
	assign coreResetN = (state_r == rss_pkg::ST_RUN) && !powerOnLow && !testResetBit &&
		!porSync_r[1] && !tstSync_r[1];
	assign portResetN = coreResetN && pinResetN;
	assign rif.causeSet = causeNow;
	assign irq = rif.irq;

	rss_regs regs (
		.clk(clk),
		.nrst(nrst),
		.porActive(porSync_r[1]),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rif(rif)
	);
endmodule
`default_nettype wire

// ---- verilog/rss_pkg.sv ----
// package: constants for the reset source sequencer
package rss_pkg;
	// clock and timing
	localparam int CLK_MHZ = 125;
	localparam int PIN_MIN_NS = 800;
	localparam int PIN_MIN_CYC = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
	// timeout choices in clock cycles, indexed by start-up/clock-source select
	localparam logic [15:0] TOUT_SEL0 = 16'h0004;
	localparam logic [15:0] TOUT_SEL1 = 16'h0040;
	localparam logic [15:0] TOUT_SEL2 = 16'h0400;
	localparam logic [15:0] TOUT_SEL3 = 16'h1000;
	// brown-out level select codes
	localparam logic [1:0] BRN_OFF = 2'h3;
	// register byte offsets
	localparam logic [3:0] OFF_CAUSE = 4'h0;
	localparam logic [3:0] OFF_IRQ = 4'h4;
	localparam logic [3:0] OFF_MASK = 4'h8;
	localparam logic [3:0] OFF_CFG = 4'hc;
	// cause bit positions
	localparam int CB_POR = 0;
	localparam int CB_EXT = 1;
	localparam int CB_BRN = 2;
	localparam int CB_WDT = 3;
	localparam int CB_TST = 4;
	localparam logic [4:0] CAUSE_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;
	localparam logic [3:0] CFG_RST = 4'h0;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_HOLD = 2'b00, ST_COUNT = 2'b01, ST_RUN = 2'b11} rss_state_type;
endpackage

// ---- verilog/rss_regs.sv ----
// interface and register file for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
interface rss_reg_if;
	logic [4:0] causeSet;
	logic [4:0] cause;
	logic causeClrPor;
	logic [3:0] cfg;
	logic irq;
	modport regs(input causeSet, output cause, output causeClrPor, output cfg, output irq);
	modport core(output causeSet, input cause, input causeClrPor, input cfg, input irq);
endinterface

module rss_regs (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic porActive,
	// axi4-lite slave
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// core side
	rss_reg_if.regs rif
);
	logic [3:0] awAddr_r;
	logic awHave_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic wHave_r;
	logic [4:0] cause_r;
	logic [4:0] pend_r;
	logic [4:0] mask_r;
	logic [3:0] cfg_r;
	wire doWrite = awHave_r && wHave_r && !bvalid;
	wire doRead = arvalid && arready;
	wire wrCause = doWrite && awAddr_r == rss_pkg::OFF_CAUSE && wStrb_r[0];
	wire wrMask = doWrite && awAddr_r == rss_pkg::OFF_MASK && wStrb_r[0];
	wire wrCfg = doWrite && awAddr_r == rss_pkg::OFF_CFG && wStrb_r[0];
	wire wrKnown = awAddr_r == rss_pkg::OFF_CAUSE || awAddr_r == rss_pkg::OFF_MASK ||
		awAddr_r == rss_pkg::OFF_CFG || awAddr_r == rss_pkg::OFF_IRQ;
	wire rdIrq = doRead && araddr == rss_pkg::OFF_IRQ;
	wire rdKnown = araddr == rss_pkg::OFF_CAUSE || araddr == rss_pkg::OFF_MASK ||
		araddr == rss_pkg::OFF_CFG || araddr == rss_pkg::OFF_IRQ;
	// written zeros clear cause flags; power-on clears the others
	wire [4:0] causeKeep = wrCause ? (cause_r & wData_r[4:0]) : cause_r;
	wire [4:0] porClr = porActive ? 5'h1e : 5'h00;
	assign awready = !awHave_r;
	assign wready = !wHave_r;
	assign arready = !rvalid;
	assign rif.cause = cause_r;
	assign rif.cfg = cfg_r;
	assign rif.irq = |(pend_r & mask_r);
	assign rif.causeClrPor = wrCause && !wData_r[rss_pkg::CB_POR];
	// ************
	// bus handshakes
	// ************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
			awAddr_r <= 4'h0;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			bresp <= rss_pkg::AXI_OKAY;
			rresp <= rss_pkg::AXI_OKAY;
			rdata <= 32'h00000000;
		end else begin
			if (awvalid && awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wrKnown ? rss_pkg::AXI_OKAY : rss_pkg::AXI_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (doRead) begin
				rvalid <= 1'b1;
				rresp <= rdKnown ? rss_pkg::AXI_OKAY : rss_pkg::AXI_SLVERR;
				case (araddr)
					rss_pkg::OFF_CAUSE: rdata <= {27'h0, cause_r};
					rss_pkg::OFF_IRQ: rdata <= {27'h0, pend_r};
					rss_pkg::OFF_MASK: rdata <= {27'h0, mask_r};
					rss_pkg::OFF_CFG: rdata <= {28'h0, cfg_r};
					default: rdata <= 32'h00000000;
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
	// ************
	// registers
	// ************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mask_r <= rss_pkg::MASK_RST;
			cfg_r <= rss_pkg::CFG_RST;
			pend_r <= 5'h00;
		end else begin
			if (wrMask) begin
				mask_r <= wData_r[4:0];
			end
			if (wrCfg) begin
				cfg_r <= wData_r[3:0];
			end
			// a read of the irq register clears; a new event in the same cycle survives
			pend_r <= (rdIrq ? 5'h00 : pend_r) | rif.causeSet;
		end
	end
	// cause flags live through the core reset; set wins over clear
	always_ff @(posedge clk) begin
		cause_r <= (causeKeep & ~porClr) | rif.causeSet;
	end
endmodule
`default_nettype wire

// ---- tb/rss_props.sv ----
// checker: properties of the reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rss_props (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// sources and selects
	input wire logic powerOnLow,
	input wire logic pinResetN,
	input wire logic watchdogExpire,
	input wire logic watchdogEnable,
	input wire logic [1:0] brownoutCompare,
	input wire logic testResetBit,
	input wire logic [1:0] brownoutLevelSelect,
	input wire logic [1:0] startupTimeSelect,
	input wire logic [1:0] clockSourceSelect,
	// outputs
	input wire logic coreResetN,
	input wire logic portResetN,
	input wire logic [1:0] brownoutThresholdSel
);
	// ********************
	// helper counters
	// ********************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	localparam logic [15:0] TT [4] = '{rss_pkg::TOUT_SEL0, rss_pkg::TOUT_SEL1,
		rss_pkg::TOUT_SEL2, rss_pkg::TOUT_SEL3};
	logic brnOn;
	logic src;
	logic [15:0] tout;
	logic [15:0] quiet_r;
	logic [15:0] pinLow_r;
	assign brnOn = brownoutCompare[0] && brownoutLevelSelect != rss_pkg::BRN_OFF;
	assign src = powerOnLow || !pinResetN || testResetBit || brnOn ||
		(watchdogExpire && watchdogEnable);
	assign tout = TT[startupTimeSelect ^ clockSourceSelect];
	// saturate so a long quiet spell never wraps back under the timeout
	always_ff @(posedge clk) begin
		quiet_r <= (!nrst || src) ? 16'h0000 : quiet_r + {15'h0000, ~&quiet_r};
		pinLow_r <= (!nrst || pinResetN) ? 16'h0000 : pinLow_r + {15'h0000, ~&pinLow_r};
	end
	a_por_holds: assert property (powerOnLow |-> !coreResetN && !portResetN)
		else $error("core released while supply low");
	a_test_holds: assert property (testResetBit |-> !coreResetN)
		else $error("core released while test bit set");
	a_port_follows: assert property (!coreResetN |-> !portResetN)
		else $error("ports not reset with core");
	a_release_min: assert property ($rose(coreResetN) |-> quiet_r + 16'h0001 >= tout)
		else $error("core released before timeout");
	a_release_max: assert property ($rose(coreResetN) |-> quiet_r <= tout + 16'h000a)
		else $error("core released too late");
	a_pin_qualify: assert property (pinLow_r > rss_pkg::PIN_MIN_CYC + 4 |-> !portResetN && !coreResetN)
		else $error("long pin low did not reset");
	a_wdog_fires: assert property (watchdogEnable && $rose(watchdogExpire) |-> ##[1:4] !coreResetN)
		else $error("watchdog expiry did not reset");
	a_brn_fires: assert property (brnOn [*4] |-> !coreResetN)
		else $error("brown-out did not reset");
	a_brn_level: assert property (brownoutThresholdSel == brownoutLevelSelect)
		else $error("brown-out level not passed on");
	c_release: cover property ($rose(coreResetN));
	c_pin_long: cover property (pinLow_r == 16'h0068);
	c_wdog: cover property (watchdogEnable && $rose(watchdogExpire));
endmodule
`default_nettype wire

// ---- tb/rss_partner.sv ----
// partner: supply detectors, reset pin and watchdog
`timescale 1ns/1ps
`default_nettype none
module rss_partner (
	// clock
	input wire logic clk,
	// detector, pin and watchdog outputs
	output logic powerOnLow,
	output logic pinResetN,
	output logic watchdogExpire,
	output logic [1:0] brownoutCompare,
	output logic testResetBit
);
	// supply starts below threshold, as at power-up
	initial begin
		powerOnLow = 1'b1;
		pinResetN = 1'b1;
		watchdogExpire = 1'b0;
		brownoutCompare = 2'h0;
		testResetBit = 1'b0;
	end
	task automatic setLevel(input logic por, input logic brownout_monitor, input logic tst);
		@(posedge clk);
		powerOnLow <= por;
		brownoutCompare <= {1'b0, brownout_monitor};
		testResetBit <= tst;
	endtask
	// only pulses past the filter length are offered
	task automatic pinLow(input int n);
		@(posedge clk);
		pinResetN <= 1'b0;
		repeat (n) @(posedge clk);
		pinResetN <= 1'b1;
	endtask
	task automatic fireWdog();
		@(posedge clk);
		watchdogExpire <= 1'b1;
		@(posedge clk);
		watchdogExpire <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: reset sequencer through sources and register bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, nrst, watchdogEnable, powerOnLow, pinResetN, watchdogExpire, testResetBit;
	logic [1:0] brownoutCompare, brownoutLevelSelect, startupTimeSelect, clockSourceSelect;
	logic coreResetN, portResetN, irq, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] brownoutThresholdSel, bresp, rresp, br, rr;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rv;
	int num_errors, num_checks, n;
	int touts[4] = '{rss_pkg::TOUT_SEL0, rss_pkg::TOUT_SEL1, rss_pkg::TOUT_SEL2, rss_pkg::TOUT_SEL3};
	rss_top DUT (.clk, .nrst, .powerOnLow, .pinResetN, .watchdogExpire, .watchdogEnable,
		.brownoutCompare, .testResetBit, .brownoutLevelSelect, .startupTimeSelect,
		.clockSourceSelect, .coreResetN, .portResetN, .brownoutThresholdSel, .irq,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	rss_partner pm (.clk, .powerOnLow, .pinResetN, .watchdogExpire, .brownoutCompare, .testResetBit);
	// ********************
	// bus and check tasks
	// ********************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ready is looked at on the falling edge, so the handshake edge is never raced
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		fork
			begin
				do @(negedge clk); while (!awready);
				@(posedge clk);
				awvalid <= 1'b0;
			end
			begin
				do @(negedge clk); while (!wready);
				@(posedge clk);
				wvalid <= 1'b0;
			end
		join
		bready <= 1'b1;
		do @(negedge clk); while (!bvalid);
		br = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(negedge clk); while (!rvalid);
		d = rdata;
		rr = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic relChk(input int t);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (coreResetN !== 1'b1 && n < 6000);
		chk(n + 1 >= t && n <= t + 10, 1);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ********************
	// tests
	// ********************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test();
	end
	initial begin
		{nrst, watchdogEnable, startupTimeSelect, clockSourceSelect} = '0;
		brownoutLevelSelect = rss_pkg::BRN_OFF;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		num_errors = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(negedge clk);
		chk(coreResetN, 1'b0);
		pm.setLevel(1'b0, 1'b0, 1'b0);
		relChk(4);
		rd(rss_pkg::OFF_IRQ, rv);
		chk(rv, 32'h1);
		rd(rss_pkg::OFF_CAUSE, rv);
		chk(rv, 32'h1);
		rd(rss_pkg::OFF_MASK, rv);
		chk(rv, 32'(rss_pkg::MASK_RST));
		wr(rss_pkg::OFF_MASK, 32'h1f);
		chk(br, rss_pkg::AXI_OKAY);
		chk(irq, 1'b0);
		wr(rss_pkg::OFF_CFG, 32'ha);
		wstrb <= 4'h0;
		wr(rss_pkg::OFF_CFG, 32'h5);
		wstrb <= 4'hf;
		rd(rss_pkg::OFF_CFG, rv);
		chk(rv, 32'ha);
		rd(4'h2, rv);
		chk(rr, rss_pkg::AXI_SLVERR);
		chk(rv, 32'h0);
		$display("test power-on finished");
		fork
			pm.pinLow(rss_pkg::PIN_MIN_CYC + 10);
			begin
				repeat (rss_pkg::PIN_MIN_CYC + 8) @(negedge clk);
				chk({portResetN, coreResetN}, 2'h0);
			end
		join
		relChk(4);
		chk(irq, 1'b1);
		rd(rss_pkg::OFF_IRQ, rv);
		chk(rv, 32'h2);
		chk(irq, 1'b0);
		rd(rss_pkg::OFF_CAUSE, rv);
		chk(rv, 32'h3);
		wr(rss_pkg::OFF_CAUSE, 32'h0);
		rd(rss_pkg::OFF_CAUSE, rv);
		chk(rv, 32'h0);
		$display("test pin finished");
		pm.fireWdog();
		repeat (6) @(negedge clk);
		chk(coreResetN, 1'b1);
		@(posedge clk);
		watchdogEnable <= 1'b1;
		pm.fireWdog();
		repeat (4) @(negedge clk);
		chk(coreResetN, 1'b0);
		relChk(4);
		pm.setLevel(1'b0, 1'b1, 1'b0);
		repeat (10) @(negedge clk);
		chk(coreResetN, 1'b1);
		@(posedge clk);
		brownoutLevelSelect <= 2'h1;
		repeat (6) @(negedge clk);
		chk({coreResetN, brownoutThresholdSel}, 3'h1);
		pm.setLevel(1'b0, 1'b0, 1'b0);
		relChk(4);
		$display("test watchdog and brown-out finished");
		for (int i = 0; i < 4; i++) begin
			pm.setLevel(1'b0, 1'b0, 1'b1);
			startupTimeSelect <= 2'(i);
			repeat (2) @(negedge clk);
			chk({coreResetN, portResetN}, 2'h0);
			pm.setLevel(1'b0, 1'b0, 1'b0);
			relChk(touts[i]);
		end
		rd(rss_pkg::OFF_CAUSE, rv);
		chk(rv, 32'h1c);
		pm.setLevel(1'b1, 1'b0, 1'b0);
		repeat (2) @(negedge clk);
		chk(coreResetN, 1'b0);
		pm.setLevel(1'b0, 1'b0, 1'b0);
		relChk(touts[3]);
		rd(rss_pkg::OFF_CAUSE, rv);
		chk(rv, 32'h1);
		$display("test timeouts and power loss finished");
		finish_test();
	end
endmodule
bind rss_top rss_props P (.clk, .nrst, .powerOnLow, .pinResetN, .watchdogExpire,
	.watchdogEnable, .brownoutCompare, .testResetBit, .brownoutLevelSelect, .startupTimeSelect,
	.clockSourceSelect, .coreResetN, .portResetN, .brownoutThresholdSel);
`default_nettype wire
